// File: design/hvwk_filter.sv
// Purpose: edge filter; accepts a new level that stays stable for the interval
// Assumes: input already synchronised to the clock
// Notes:   a crossing back restarts the wait from the stable level
`timescale 1ns/10ps
`default_nettype none
module hvwk_filter #(
  parameter int unsigned CYCLES = hvwk_pkg::FILTER_CYCLES
) (
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_sys_rst,
  // sampled input and gate
  input  wire logic i_level,
  input  wire logic i_gate,
  // filtered result
  output logic      o_level,
  output logic      o_event
);
  if (CYCLES < 2) begin : g_bad_cycles
    $error("hvwk_filter: CYCLES too small");
  end
  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);
  hvwk_pkg::hvwk_fstate_t state_reg;   // idle or timing
  logic [W-1:0]           count_reg;   // cycles the new level held
  logic                   stable_reg;  // accepted level
  logic                   event_reg;   // one-cycle accept pulse
  wire                    differs = i_level != stable_reg;
  wire                    expired = count_reg == LAST;
  // interval timer: any crossing starts it, a crossing back drops it
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || !i_gate) begin
      state_reg  <= hvwk_pkg::HVWK_F_IDLE;
      count_reg  <= '0;
      event_reg  <= 1'b0;
      if (i_sys_rst) stable_reg <= 1'b0;
      else stable_reg <= i_level;            // track quietly while gated
    end else begin
      event_reg <= 1'b0;
      case (state_reg)
        hvwk_pkg::HVWK_F_IDLE: begin
          count_reg <= '0;
          if (differs) state_reg <= hvwk_pkg::HVWK_F_RUN; // [RULE4]
        end
        default: begin
          if (!differs) begin
            state_reg <= hvwk_pkg::HVWK_F_IDLE;          // crossed back [RULE4]
          end else if (expired) begin
            stable_reg <= i_level;                       // both directions [RULE1]
            event_reg  <= 1'b1;
            state_reg  <= hvwk_pkg::HVWK_F_IDLE;
          end else begin
            count_reg <= count_reg + 1'b1;
          end
        end
      endcase
    end
  end
  assign o_level = stable_reg;
  assign o_event = event_reg;
endmodule // hvwk_filter
`default_nettype wire

// File: design/hvwk_monitor.sv
// Purpose: high-voltage wake input monitor with APB register access
// Assumes: comparator outputs are asynchronous; mode comes from the chip controller
// Notes:   analog comparator, measurement unit and pulse generator live outside
//
// Contract
// [RULE1] rising and falling crossings both signal wakes
// [RULE2] normal/stop interrupt; sleep/fail-safe wake device
// [RULE3] static or cyclic sense selectable
// [RULE4] crossing starts filter; cross back cancels
// [RULE5] filter interval between 13 and 20 us
// [RULE6] software enables pin wake; device obeys
// [RULE7] detected wake sets flag in first status
// [RULE8] level bit live, or sampled in cyclic; static sense updates the bit only in init, normal and stop modes
// [RULE9] general pin wake: same filter, second status
// [RULE10] pull code: none, down, up, auto
// [RULE11] auto mode pulls toward detected level
// [RULE12] cyclic: sample during switch on-time, change wakes
// [RULE13] cyclic needs general pin as timer switch
// [RULE14] measurement routes voltage, disables fail/gp/wake
// [RULE15] measurement disables pulls, blocks wake signal
// [RULE16] measurement ignores settings, writes still stored
// [RULE17] measurement freezes flag, clears level bits
// [RULE18] measurement plus only pin source: sleep fails
// [RULE19] unpulled input should be tied on board
// [RULE20] interrupt only from enabled wake sources
// [RULE21] wake flags latch until cleared
// [RULE22] comparator synchronised before filter
`timescale 1ns/10ps
`default_nettype none
module hvwk_monitor #(
  parameter int unsigned FILTER_CYCLES = hvwk_pkg::FILTER_CYCLES
) (
  // clock and reset
  input  wire logic                  i_clock,
  input  wire logic                  i_sys_rst,
  // apb slave
  input  wire logic                  i_psel,
  input  wire logic                  i_penable,
  input  wire logic                  i_pwrite,
  input  wire logic [7:0]            i_paddr,
  input  wire logic [31:0]           i_pwdata,
  output logic      [31:0]           o_prdata,
  output logic                       o_pready,
  output logic                       o_pslverr,
  // comparator inputs (asynchronous)
  input  wire logic                  i_hv_wake_pin,
  input  wire logic                  i_gp_wake_pin,
  // chip context
  input  wire logic [2:0]            i_chip_mode,
  input  wire logic                  i_hs_on_window,
  input  wire logic                  i_sleep_request,
  // outputs
  output logic                       o_wake_irq,
  output logic                       o_device_wake,
  output hvwk_pkg::hvwk_pull_drv_t   o_pull,
  output logic                       o_meas_route,
  output logic                       o_fail_gp_block,
  output logic                       o_restart_request
);
  // filter length must meet the 13..20 us window at this clock
  localparam int unsigned MIN_CYC = (13 * hvwk_pkg::CLK_MHZ);
  localparam int unsigned MAX_CYC = (20 * hvwk_pkg::CLK_MHZ);
  if (FILTER_CYCLES < MIN_CYC || FILTER_CYCLES > MAX_CYC) begin : g_bad_filter
    $error("hvwk_monitor: filter interval out of range");  // [RULE5]
  end

  // synchronisers: stage one read only by stage two
  logic hv_s1_reg;        // first stage pin
  logic hv_s2_reg;        // second stage pin
  logic gp_s1_reg;        // first stage general pin
  logic gp_s2_reg;        // second stage general pin
  logic hs_s1_reg;        // first stage switch window
  logic hs_s2_reg;        // second stage switch window
  always_ff @(posedge i_clock) begin
    hv_s1_reg <= i_hv_wake_pin;     // [RULE22]
    hv_s2_reg <= hv_s1_reg;
    gp_s1_reg <= i_gp_wake_pin;
    gp_s2_reg <= gp_s1_reg;
    hs_s1_reg <= i_hs_on_window;
    hs_s2_reg <= hs_s1_reg;
  end

  // control registers
  logic [2:0]  wake_ctrl_reg;       // pin, gp and other source enables
  logic [1:0]  pull_ctrl_reg;       // pull select code
  logic [3:0]  meas_ctrl_reg;       // measure, cyclic, gp wake, gp timer switch
  // status registers
  logic        pin_flag_reg;        // pin_wake_flag
  logic        gp_flag_reg;         // general pin wake flag
  logic        level_reg;           // pin_level_status
  logic        cfg_err_reg;         // configuration error flag
  logic        cyc_sample_reg;      // last cyclic sample
  logic        cyc_valid_reg;       // a sample has been taken
  logic        hs_prev_reg;         // switch window one cycle ago
  logic        pull_level_reg;      // level steering auto pull
  logic        sleep_prev_reg;      // sleep request edge detect

  // decoded settings
  wire meas_en    = meas_ctrl_reg[hvwk_pkg::BIT_MEAS_EN];
  wire cyclic     = meas_ctrl_reg[hvwk_pkg::BIT_CYCLIC];                     // [RULE3]
  wire gp_wake_en = meas_ctrl_reg[hvwk_pkg::BIT_GP_WAKE_CFG] && !meas_en;    // [RULE14]
  wire cyc_ok     = cyclic && meas_ctrl_reg[hvwk_pkg::BIT_GP_HS_TIMER];      // [RULE13]
  wire pin_en     = wake_ctrl_reg[hvwk_pkg::BIT_PIN_EN] && !meas_en;         // [RULE6] [RULE16]
  wire gp_en      = wake_ctrl_reg[hvwk_pkg::BIT_GP_EN];
  wire other_en   = wake_ctrl_reg[hvwk_pkg::BIT_OTHER_EN];
  // the internal wake signal is blocked while measuring
  wire pin_gate   = !meas_en && !cyclic;                                     // [RULE15]

  // static filters for the pin and the general pin
  logic pin_filt_level;   // filtered pin level
  logic pin_filt_event;   // accepted pin crossing
  logic gp_filt_event;    // accepted general pin crossing
  hvwk_filter #(.CYCLES(FILTER_CYCLES)) u_pin_filter (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_level   (hv_s2_reg),
    .i_gate    (pin_gate),
    .o_level   (pin_filt_level),
    .o_event   (pin_filt_event)
  );
  hvwk_filter #(.CYCLES(FILTER_CYCLES)) u_gp_filter (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_level   (gp_s2_reg),
    .i_gate    (gp_wake_en),                                                 // [RULE9]
    .o_level   (),
    .o_event   (gp_filt_event)
  );

  // cyclic sense sample at the end of each switch on-time
  wire hs_fall     = hs_prev_reg && !hs_s2_reg;
  wire cyc_take    = cyc_ok && !meas_en && hs_fall;                          // [RULE12]
  wire cyc_event   = cyc_take && cyc_valid_reg && (hv_s2_reg != cyc_sample_reg);
  wire pin_event   = (pin_filt_event || cyc_event) && pin_en;                // [RULE1]
  wire gp_event    = gp_filt_event && gp_en && gp_wake_en;

  // apb decode
  wire acc        = i_psel && i_penable;
  wire wr         = acc && i_pwrite;
  wire rd         = acc && !i_pwrite;
  wire hit_wctrl  = i_paddr == hvwk_pkg::OFS_WAKE_CTRL;
  wire hit_pctrl  = i_paddr == hvwk_pkg::OFS_PULL_CTRL;
  wire hit_mctrl  = i_paddr == hvwk_pkg::OFS_MEAS_CTRL;
  wire hit_st1    = i_paddr == hvwk_pkg::OFS_STAT_FIRST;
  wire hit_st2    = i_paddr == hvwk_pkg::OFS_STAT_SECOND;
  wire hit_lvl    = i_paddr == hvwk_pkg::OFS_LEVEL_STAT;
  wire hit_err    = i_paddr == hvwk_pkg::OFS_CFG_ERR;
  wire mapped     = hit_wctrl | hit_pctrl | hit_mctrl | hit_st1 | hit_st2 | hit_lvl | hit_err;
  // write-one-to-clear for flags
  wire clr_pin    = wr && hit_st1 && i_pwdata[hvwk_pkg::BIT_FLAG];
  wire clr_gp     = wr && hit_st2 && i_pwdata[hvwk_pkg::BIT_FLAG];
  wire clr_err    = wr && hit_err && i_pwdata[hvwk_pkg::BIT_FLAG];
  // read mux
  logic [31:0] rd_mux;   // selected read word
  assign rd_mux = hit_wctrl ? {29'h0, wake_ctrl_reg} :
                  hit_pctrl ? {30'h0, pull_ctrl_reg} :
                  hit_mctrl ? {28'h0, meas_ctrl_reg} :
                  hit_st1   ? {31'h0, pin_flag_reg} :
                  hit_st2   ? {31'h0, gp_flag_reg} :
                  hit_lvl   ? {31'h0, level_reg} :
                  hit_err   ? {31'h0, cfg_err_reg} : 32'h0000_0000;

  // chip mode decode
  wire mode_irq   = (i_chip_mode == hvwk_pkg::HVWK_MODE_NORMAL) ||
                    (i_chip_mode == hvwk_pkg::HVWK_MODE_STOP);
  wire mode_wake  = (i_chip_mode == hvwk_pkg::HVWK_MODE_SLEEP) ||
                    (i_chip_mode == hvwk_pkg::HVWK_MODE_FAIL);
  wire mode_live  = mode_irq || (i_chip_mode == hvwk_pkg::HVWK_MODE_INIT);
  wire sleep_rise = i_sleep_request && !sleep_prev_reg;
  wire sleep_bad  = sleep_rise && meas_en && wake_ctrl_reg[hvwk_pkg::BIT_PIN_EN]
                    && !gp_en && !other_en;                                  // [RULE18]

  // pull selection; settings ignored while measuring
  hvwk_pkg::hvwk_pull_t pull_code;   // active pull code
  assign pull_code = hvwk_pkg::hvwk_pull_t'(pull_ctrl_reg);
  hvwk_pkg::hvwk_pull_drv_t pull_next;  // next pull drive
  always_comb begin
    pull_next = '0;
    if (!meas_en) begin                                                      // [RULE15]
      case (pull_code)                                                       // [RULE10]
        hvwk_pkg::HVWK_PULL_DOWN: pull_next.pull_down = 1'b1;
        hvwk_pkg::HVWK_PULL_UP:   pull_next.pull_up   = 1'b1;
        hvwk_pkg::HVWK_PULL_AUTO: begin
          pull_next.pull_up   = pull_level_reg;                              // [RULE11]
          pull_next.pull_down = !pull_level_reg;
        end
        default: pull_next = '0;
      endcase
    end
  end

  // software control registers; writes land even while measuring
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      wake_ctrl_reg <= 3'h0;
      pull_ctrl_reg <= hvwk_pkg::HVWK_PULL_NONE;
      meas_ctrl_reg <= 4'h0;
    end else if (wr) begin
      if (hit_wctrl) wake_ctrl_reg <= i_pwdata[2:0];                         // [RULE16]
      if (hit_pctrl) pull_ctrl_reg <= i_pwdata[1:0];
      if (hit_mctrl) meas_ctrl_reg <= i_pwdata[3:0];
    end
  end

  // sticky flags; a new event wins over a clear in the same cycle
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      pin_flag_reg <= 1'b0;
      gp_flag_reg  <= 1'b0;
      cfg_err_reg  <= 1'b0;
    end else begin
      if (pin_event && !meas_en) pin_flag_reg <= 1'b1;                       // [RULE7] [RULE17]
      else if (clr_pin) pin_flag_reg <= 1'b0;                                // [RULE21]
      if (gp_event) gp_flag_reg <= 1'b1;                                     // [RULE9]
      else if (clr_gp) gp_flag_reg <= 1'b0;
      if (sleep_bad) cfg_err_reg <= 1'b1;                                    // [RULE18]
      else if (clr_err) cfg_err_reg <= 1'b0;
    end
  end

  // cyclic sampling and level reporting
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      cyc_sample_reg <= 1'b0;
      cyc_valid_reg  <= 1'b0;
      hs_prev_reg    <= 1'b0;
      level_reg      <= 1'b0;
      pull_level_reg <= 1'b0;
      sleep_prev_reg <= 1'b0;
    end else begin
      hs_prev_reg    <= hs_s2_reg;
      sleep_prev_reg <= i_sleep_request;
      if (!cyc_ok || meas_en) cyc_valid_reg <= 1'b0;
      else if (cyc_take) begin
        cyc_sample_reg <= hv_s2_reg;                                         // [RULE12]
        cyc_valid_reg  <= 1'b1;
      end
      // auto pull follows the filtered level, or the live one in cyclic
      pull_level_reg <= cyclic ? hv_s2_reg : pin_filt_level;
      if (meas_en) level_reg <= 1'b0;                                        // [RULE17]
      else if (cyclic) level_reg <= cyc_sample_reg;                          // [RULE8]
      else if (mode_live) level_reg <= hv_s2_reg;                            // [RULE8]
    end
  end

  // outputs, all registered
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_prdata          <= 32'h0000_0000;
      o_pready          <= 1'b0;
      o_pslverr         <= 1'b0;
      o_wake_irq        <= 1'b0;
      o_device_wake     <= 1'b0;
      o_pull            <= '0;
      o_meas_route      <= 1'b0;
      o_fail_gp_block   <= 1'b0;
      o_restart_request <= 1'b0;
    end else begin
      // one wait cycle: ready answers in the second access cycle
      o_pready  <= acc && !o_pready;
      o_pslverr <= acc && !o_pready && !mapped;
      if (rd && !o_pready) o_prdata <= rd_mux;
      o_wake_irq        <= (pin_event || gp_event) && mode_irq;              // [RULE2] [RULE20]
      o_device_wake     <= (pin_event || gp_event) && mode_wake;             // [RULE2]
      o_pull            <= pull_next;
      o_meas_route      <= meas_en;                                          // [RULE14]
      o_fail_gp_block   <= meas_en;                                          // [RULE14]
      o_restart_request <= sleep_bad;                                        // [RULE18]
    end
  end
endmodule // hvwk_monitor
`default_nettype wire

// File: dv/hvwk_monitor_asserts.sv
// Purpose: port assertions for the wake monitor
// Assumes: bench changes chip mode only while no wake is pending
// Notes:   pin ages count cycles since each input last moved
`timescale 1ns/10ps
`default_nettype none
module hvwk_monitor_checker #(
  parameter int unsigned FILTER_CYCLES = 4000
) (
  // clock, reset and inputs
  input wire logic                     i_clock,
  input wire logic                     i_sys_rst,
  input wire logic                     i_psel,
  input wire logic                     i_penable,
  input wire logic                     i_hv_wake_pin,
  input wire logic                     i_gp_wake_pin,
  input wire logic [2:0]               i_chip_mode,
  input wire logic                     i_hs_on_window,
  input wire logic                     i_sleep_request,
  // outputs watched
  input wire logic                     o_pready,
  input wire logic                     o_pslverr,
  input wire logic                     o_wake_irq,
  input wire logic                     o_device_wake,
  input wire hvwk_pkg::hvwk_pull_drv_t o_pull,
  input wire logic                     o_meas_route,
  input wire logic                     o_fail_gp_block,
  input wire logic                     o_restart_request
);
  localparam int MIN_FILT = 3250; // shortest legal filter span
  logic [12:0] hv_age_reg, gp_age_reg, hs_age_reg; // saturating ages
  logic        hv_q, gp_q, hs_q;                   // last seen levels
  logic        any_evt;                            // either wake pulse
  assign any_evt = o_wake_irq || o_device_wake;
  // a move restarts the age; saturation keeps old inputs legal
  always_ff @(posedge i_clock) begin
    hv_q <= i_hv_wake_pin;
    gp_q <= i_gp_wake_pin;
    hs_q <= i_hs_on_window;
    hv_age_reg <= (i_sys_rst || hv_q != i_hv_wake_pin) ? '0 : hv_age_reg + 13'(~&hv_age_reg);
    gp_age_reg <= (i_sys_rst || gp_q != i_gp_wake_pin) ? '0 : gp_age_reg + 13'(~&gp_age_reg);
    hs_age_reg <= (i_sys_rst || hs_q != i_hs_on_window) ? '0 : hs_age_reg + 13'(~&hs_age_reg);
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  a_ready_pulse: assert property (o_pready |-> $past(i_psel && i_penable) ##1 !o_pready)
    else $error("pready not a single answer to an access");
  a_err_ready: assert property (o_pslverr |-> o_pready)
    else $error("slave error without ready");
  a_pull_exclusive: assert property (!(o_pull.pull_up && o_pull.pull_down))
    else $error("both current sources on");
  a_meas_pulls: assert property (o_meas_route && $past(o_meas_route) |-> o_pull == '0)
    else $error("pull source on while measuring");
  a_meas_block: assert property (o_meas_route && $past(o_meas_route) |-> o_fail_gp_block)
    else $error("shared pin functions not blocked while measuring");
  a_meas_quiet: assert property (o_meas_route && $past(o_meas_route, 8) |-> !any_evt)
    else $error("wake signalled while measuring");
  a_irq_mode: assert property (o_wake_irq |-> $past(i_chip_mode) inside {3'h1, 3'h2})
    else $error("interrupt outside normal or stop");
  a_wake_mode: assert property (o_device_wake |-> $past(i_chip_mode) inside {3'h3, 3'h4})
    else $error("device wake outside sleep or fail-safe");
  a_filter_min: assert property (any_evt && hs_age_reg > 13'h40 |-> hv_age_reg >= MIN_FILT || gp_age_reg >= MIN_FILT)
    else $error("wake before the filter span ran out");
  a_restart_cause: assert property (o_restart_request |-> o_meas_route && i_sleep_request)
    else $error("restart request without measuring sleep attempt");
endmodule // hvwk_monitor_checker
bind hvwk_monitor hvwk_monitor_checker #(.FILTER_CYCLES(FILTER_CYCLES)) u_hvwk_chk (
  .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable),
  .i_hv_wake_pin(i_hv_wake_pin), .i_gp_wake_pin(i_gp_wake_pin), .i_chip_mode(i_chip_mode),
  .i_hs_on_window(i_hs_on_window), .i_sleep_request(i_sleep_request), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_wake_irq(o_wake_irq), .o_device_wake(o_device_wake),
  .o_pull(o_pull), .o_meas_route(o_meas_route), .o_fail_gp_block(o_fail_gp_block),
  .o_restart_request(o_restart_request));
`default_nettype wire

// File: dv/hvwk_pin_model.sv
// Purpose: wake pin as seen from the board side
// Assumes: bench either drives the pin or leaves it open
// Notes:   an open pin with no source wanders every cycle
`timescale 1ns/10ps
`default_nettype none
module hvwk_pin_model (
  // clock
  input  wire logic                     i_clock,
  // bench drive
  input  wire logic                     i_drive_en,
  input  wire logic                     i_drive_level,
  // device current sources
  input  wire hvwk_pkg::hvwk_pull_drv_t i_pull,
  // pin level
  output logic                          o_pin
);
  logic wander_reg = 1'b0; // stands in for a floating input
  // toggling makes an untied pin visible instead of settling quietly
  always_ff @(posedge i_clock) wander_reg <= ~wander_reg;
  // driven, else pulled, else floating
  assign o_pin = i_drive_en ? i_drive_level : i_pull.pull_up ? 1'b1 :
                 i_pull.pull_down ? 1'b0 : wander_reg;
endmodule // hvwk_pin_model
`default_nettype wire

// File: dv/tb_hvwk_monitor.sv
// Purpose: register and pin level tests of the wake monitor
// Assumes: full filter length, about 26k cycles in all
// Notes:   apb tasks wait on pready; filter spans are measured
`timescale 1ns/10ps
`default_nettype none
module tb_hvwk_monitor;
  logic        i_clock, i_sys_rst, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        gp_pin, hs_win, sleep_req, hv_en, hv_lvl, hv_pin;
  logic        irq, dwake, meas, fgb, rst_req;
  logic [2:0]  mode;
  hvwk_pkg::hvwk_pull_drv_t pull;
  int          err_total, cmp_count, irq_cnt, n, m;
  hvwk_monitor DUT (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_hv_wake_pin(hv_pin),
    .i_gp_wake_pin(gp_pin), .i_chip_mode(mode), .i_hs_on_window(hs_win),
    .i_sleep_request(sleep_req), .o_wake_irq(irq), .o_device_wake(dwake), .o_pull(pull),
    .o_meas_route(meas), .o_fail_gp_block(fgb), .o_restart_request(rst_req));
  hvwk_pin_model u_pin (.i_clock(i_clock), .i_drive_en(hv_en), .i_drive_level(hv_lvl),
    .i_pull(pull), .o_pin(hv_pin));
  // clock, 4 ns period
  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end
  // count interrupt pulses
  always @(posedge i_clock) if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
  task automatic chk_word(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic chk_bit(input string s, input logic [1:0] e, input logic [1:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %b seen %b", s, e, g);
    end
  endtask
  task automatic cycles(input int k);
    repeat (k) @(posedge i_clock);
  endtask
  // one transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    do begin
      @(posedge i_clock);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rdat = prdata;
    rerr = pslverr;
    if (pready !== 1'b1) chk_bit("pready", 2'h1, {1'b0, pready});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input string s, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk_word(s, e, rdat);
  endtask
  // cycles until a wake pulse, bounded
  task automatic wait_evt(output int c);
    c = 0;
    while (!(irq === 1'b1 || dwake === 1'b1) && c < 6000) begin
      @(posedge i_clock);
      c++;
    end
  endtask
  task automatic hs_pulse();
    hs_win <= 1'b1;
    cycles(10);
    hs_win <= 1'b0;
    cycles(10);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // watchdog well past the expected run
  initial begin
    #300000;
    err_total++;
    wrap_up();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, gp_pin, hs_win, sleep_req, hv_lvl} = '0;
    {err_total, cmp_count, irq_cnt} = '0;
    i_sys_rst = 1'b1;
    hv_en = 1'b1;
    mode = 3'h1;
    cycles(16);
    i_sys_rst <= 1'b0;
    @(posedge i_clock);
    for (int a = 0; a < 28; a += 4) rd("reset", 8'(a), 32'h0);
    apb(1'b0, 8'h1C, 32'h0);
    chk_bit("unmapped", 2'h1, {1'b0, rerr});
    for (int c = 0; c < 3; c++) begin
      wr(8'h04, 32'(c));
      rd("pull code", 8'h04, 32'(c));
      chk_bit("pull drive", 2'(c), pull);
    end
    // static sense: glitch, then a held rise
    wr(8'h00, 32'h1);
    hv_lvl <= 1'b1;
    cycles(1000);
    hv_lvl <= 1'b0;
    cycles(4200);
    rd("glitch", 8'h0C, 32'h0);
    hv_lvl <= 1'b1;
    wait_evt(n);
    chk_bit("rise irq", 2'h1, {dwake, irq});
    chk_bit("rise span", 2'h1, {1'b0, n >= 3250 && n <= 5000});
    rd("pin flag", 8'h0C, 32'h1);
    rd("level", 8'h14, 32'h1);
    rd("flag held", 8'h0C, 32'h1);
    wr(8'h0C, 32'h1);
    rd("flag clear", 8'h0C, 32'h0);
    wr(8'h04, 32'h3);
    hv_en <= 1'b0;
    cycles(4);
    chk_bit("auto up", 2'h2, pull);
    // falling edge in sleep wakes the device
    mode <= 3'h3;
    hv_en <= 1'b1;
    hv_lvl <= 1'b0;
    wait_evt(n);
    chk_bit("fall wake", 2'h2, {dwake, irq});
    cycles(4);
    chk_bit("auto down", 2'h1, pull);
    rd("sleep flag", 8'h0C, 32'h1);
    wr(8'h0C, 32'h1);
    // pin wake disabled
    mode <= 3'h2;
    wr(8'h00, 32'h0);
    m = irq_cnt;
    hv_lvl <= 1'b1;
    cycles(4200);
    rd("disabled", 8'h0C, 32'h0);
    chk_word("no irq", 32'(m), 32'(irq_cnt));
    rd("level live", 8'h14, 32'h1);
    // general pin as wake input
    wr(8'h08, 32'h4);
    wr(8'h00, 32'h2);
    gp_pin <= 1'b1;
    wait_evt(n);
    chk_bit("gp span", 2'h3, {irq, n >= 3250 && n <= 5000});
    rd("gp flag", 8'h10, 32'h1);
    rd("pin flag idle", 8'h0C, 32'h0);
    wr(8'h10, 32'h1);
    // cyclic sense on switch windows
    wr(8'h00, 32'h1);
    wr(8'h08, 32'hA);
    hs_pulse();
    m = irq_cnt;
    hv_lvl <= 1'b0;
    cycles(2);
    hs_pulse();
    chk_word("cyclic irq", 32'(m + 1), 32'(irq_cnt));
    rd("cyclic flag", 8'h0C, 32'h1);
    hv_lvl <= 1'b1;
    cycles(5);
    rd("sampled level", 8'h14, 32'h0);
    wr(8'h0C, 32'h1);
    // measurement routing
    wr(8'h08, 32'h1);
    cycles(3);
    chk_bit("route", 2'h3, {meas, fgb});
    chk_bit("pulls off", 2'h0, pull);
    wr(8'h04, 32'h1);
    rd("pull kept", 8'h04, 32'h1);
    rd("level clr", 8'h14, 32'h0);
    hv_lvl <= 1'b0;
    cycles(4200);
    rd("meas flag", 8'h0C, 32'h0);
    sleep_req <= 1'b1;
    n = 0;
    while (rst_req !== 1'b1 && n < 50) begin
      @(posedge i_clock);
      n++;
    end
    chk_bit("restart", 2'h1, {1'b0, rst_req});
    sleep_req <= 1'b0;
    rd("cfg err", 8'h18, 32'h1);
    wrap_up();
  end
endmodule // tb_hvwk_monitor
`default_nettype wire

// File: include/hvwk_pkg.sv
// Purpose: shared constants and types for the high-voltage wake input monitor
// Assumes: 250 MHz system clock, APB register access with 32-bit data
// Notes:   offsets are byte addresses of aligned words
package hvwk_pkg;
  // clock and filter timing
  localparam int unsigned CLK_MHZ           = 250;   // system clock rate
  localparam int unsigned FILTER_NOM_NS     = 16000; // nominal filter interval
  localparam int unsigned FILTER_CYCLES     = (FILTER_NOM_NS * CLK_MHZ) / 1000;
  // register byte offsets
  localparam logic [7:0] OFS_WAKE_CTRL      = 8'h00; // wake_enable_control
  localparam logic [7:0] OFS_PULL_CTRL      = 8'h04; // pull_source_control
  localparam logic [7:0] OFS_MEAS_CTRL      = 8'h08; // measurement and sense mode
  localparam logic [7:0] OFS_STAT_FIRST     = 8'h0C; // wake_status_first
  localparam logic [7:0] OFS_STAT_SECOND    = 8'h10; // wake_status_second
  localparam logic [7:0] OFS_LEVEL_STAT     = 8'h14; // pin_level_status
  localparam logic [7:0] OFS_CFG_ERR        = 8'h18; // configuration error flag
  // field positions
  localparam int unsigned BIT_PIN_EN        = 0;     // pin wake enable
  localparam int unsigned BIT_GP_EN         = 1;     // general pin wake enable
  localparam int unsigned BIT_OTHER_EN      = 2;     // any other wake source enabled
  localparam int unsigned BIT_MEAS_EN       = 0;     // voltage_measure_enable
  localparam int unsigned BIT_CYCLIC        = 1;     // cyclic sense select
  localparam int unsigned BIT_GP_WAKE_CFG   = 2;     // general pin used as wake input
  localparam int unsigned BIT_GP_HS_TIMER   = 3;     // general pin is timer switch
  localparam int unsigned BIT_FLAG          = 0;     // flag position in status regs
  // pull select codes
  typedef enum logic [1:0] {
    HVWK_PULL_NONE = 2'b00,
    HVWK_PULL_DOWN = 2'b01,
    HVWK_PULL_UP   = 2'b10,
    HVWK_PULL_AUTO = 2'b11
  } hvwk_pull_t;
  // chip mode codes
  typedef enum logic [2:0] {
    HVWK_MODE_INIT   = 3'b000,
    HVWK_MODE_NORMAL = 3'b001,
    HVWK_MODE_STOP   = 3'b010,
    HVWK_MODE_SLEEP  = 3'b011,
    HVWK_MODE_FAIL   = 3'b100,
    HVWK_MODE_RESTART= 3'b101
  } hvwk_mode_t;
  // pull source drive pair
  typedef struct packed {
    logic pull_up;   // pull-up source on
    logic pull_down; // pull-down source on
  } hvwk_pull_drv_t;
  // filter state codes
  typedef enum logic [1:0] {
    HVWK_F_IDLE = 2'b00,
    HVWK_F_RUN  = 2'b01
  } hvwk_fstate_t;
endpackage
